/* File: common/ipvr_defs.vh */
// constants for the interrupt priority and vector resolver
// What this block does
// - every source owns a distinct vector number and table offset
// - table offset of the accepted source is four times its vector
// - software sets each pin and peripheral level 0..15 in 4-bit fields
// - sources sharing one field rank in a fixed hardwired order
// - reset clears every priority field to level 0
// - equal levels arriving together resolve by the fixed default order
// - nmi vector 11 level 16, break 12 level 15, pins 64..71
// - a level of 0 masks the source completely
// - nmi always accepted and raises the cpu mask to 15
`ifndef IPVR_DEFS_VH
`define IPVR_DEFS_VH

`define IPVR_LVL_W 5
`define IPVR_FLD_W 4
`define IPVR_VEC_W 8
`define IPVR_NPRIO 8
`define IPVR_NPINS 8
`define IPVR_NPFLD 24
`define IPVR_NSLOT 4
`define IPVR_DMA_FLDS 2
`define IPVR_DMA_STEP 2
`define IPVR_NMI_VEC 8'h0B
`define IPVR_UB_VEC 8'h0C
`define IPVR_PIN_VEC 8'h40
`define IPVR_PER_VEC 72
`define IPVR_FLD_SPAN 4
`define IPVR_NMI_LVL 5'h10
`define IPVR_UB_LVL 5'h0F
`define IPVR_NO_LVL 5'h00
`define IPVR_TOP_MASK 4'hF
`define IPVR_PRIO_RST 16'h0000
`define IPVR_OFS_PRIO 8'h00
`define IPVR_OFS_STAT 8'h20
`define IPVR_OFS_MASK 8'h24
`define IPVR_OFS_CUR 8'h28
`define IPVR_NEVT 2
`define IPVR_EVT_ACC 0
`define IPVR_EVT_NMI 1
`define IPVR_EVT_RST 2'h0

`endif

/* File: hdl/ipvr_pick.v */
// one step of the priority chain: keep the stronger of two candidates
`timescale 1ns/1ps
`default_nettype none
module ipvr_pick #(
    parameter LVL_W = 5,
    parameter VEC_W = 8
) (
    input wire [LVL_W-1:0] in_lvl,
    input wire [VEC_W-1:0] in_vec,
    input wire [LVL_W-1:0] cand_lvl,
    input wire [VEC_W-1:0] cand_vec,
    output wire [LVL_W-1:0] out_lvl,
    output wire [VEC_W-1:0] out_vec
);
    // strictly greater: earlier source wins a tie
    wire take;
    assign take = (cand_lvl > in_lvl);
    assign out_lvl = take ? cand_lvl : in_lvl;
    assign out_vec = take ? cand_vec : in_vec;
endmodule
`default_nettype wire

/* File: hdl/ipvr_evt.v */
// sticky event flags, write-one-to-clear, with mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ipvr_defs.vh"
module ipvr_evt #(
    parameter W = 2
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [W-1:0] evt,
    input wire clr_we,
    input wire [W-1:0] clr_data,
    input wire mask_we,
    input wire [W-1:0] mask_data,
    output wire [W-1:0] status,
    output wire [W-1:0] mask,
    output wire irq
);
    reg [W-1:0] stat_reg;
    reg [W-1:0] mask_reg;
    wire [W-1:0] stat_next;
    // set beats clear in the same cycle so no event is lost
    assign stat_next = (stat_reg & ~({W{clr_we}} & clr_data)) | evt;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= {W{1'b0}};
            mask_reg <= {W{1'b0}};
        end else begin
            stat_reg <= stat_next;
            if (mask_we) begin
                mask_reg <= mask_data;
            end
        end
    end
    assign status = stat_reg;
    assign mask = mask_reg;
    assign irq = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

/* File: hdl/ipvr_top.v */
// priority resolution and vector generation with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "ipvr_defs.vh"
module ipvr_top #(
    parameter ADDR_W = 8
) (
    input wire clk_sys,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    // request sources, level held by the requester until served
    input wire nmi_req,
    input wire ubrk_req,
    input wire [`IPVR_NPINS-1:0] external_request_pins,
    input wire [`IPVR_NPFLD*`IPVR_NSLOT-1:0] periph_req,
    // cpu side
    input wire [`IPVR_FLD_W-1:0] cpu_mask_lvl,
    input wire cpu_ack,
    output wire cpu_req,
    output wire [`IPVR_VEC_W-1:0] cpu_vec,
    output wire [`IPVR_LVL_W-1:0] cpu_lvl,
    output wire [31:0] cpu_vec_addr,
    output wire [`IPVR_FLD_W-1:0] cpu_new_mask,
    output wire irq
);
    localparam NSRC = 2 + `IPVR_NPINS + `IPVR_NPFLD * `IPVR_NSLOT;
    localparam LW = `IPVR_LVL_W;
    localparam VW = `IPVR_VEC_W;

    // ---------------- priority registers ----------------
    reg [15:0] prio_reg [0:`IPVR_NPRIO-1];
    wire apb_setup;
    wire apb_wr;
    wire hit_prio;
    wire hit_stat;
    wire hit_mask;
    wire hit_cur;
    wire hit_any;
    wire [2:0] prio_idx;
    wire [7:0] ofs;

    // word offset inside the block; an 8-bit window needs ADDR_W >= 8
    assign ofs = {paddr[7:2], 2'b00};
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pwrite;
    assign prio_idx = ofs[4:2];
    assign hit_prio = (ofs[7:5] == `IPVR_OFS_PRIO >> 5);
    assign hit_stat = (ofs == `IPVR_OFS_STAT);
    assign hit_mask = (ofs == `IPVR_OFS_MASK);
    assign hit_cur = (ofs == `IPVR_OFS_CUR);
    assign hit_any = hit_prio | hit_stat | hit_mask | hit_cur;

    genvar g;
    generate
        for (g = 0; g < `IPVR_NPRIO; g = g + 1) begin : g_prio
            wire sel;
            assign sel = apb_wr & hit_prio & (prio_idx == g);
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    prio_reg[g] <= `IPVR_PRIO_RST;
                end else if (sel) begin
                    // byte lanes reach the 4-bit fields
                    if (pstrb[0]) begin
                        prio_reg[g][7:0] <= pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        prio_reg[g][15:8] <= pwdata[15:8];
                    end
                end
            end
        end
    endgenerate

    // field f sits in register f/4, highest nibble first
    wire [`IPVR_FLD_W*`IPVR_NPRIO*4-1:0] fld_flat;
    generate
        for (g = 0; g < `IPVR_NPRIO * 4; g = g + 1) begin : g_fld
            assign fld_flat[g*`IPVR_FLD_W +: `IPVR_FLD_W] =
                prio_reg[g/4][(3-(g%4))*`IPVR_FLD_W +: `IPVR_FLD_W];
        end
    endgenerate

    // ---------------- source table ----------------
    wire [LW*NSRC-1:0] src_lvl;
    wire [VW*NSRC-1:0] src_vec;

    // fixed nmi and break entries, listed first
    assign src_lvl[0 +: LW] = nmi_req ? `IPVR_NMI_LVL : `IPVR_NO_LVL;
    assign src_vec[0 +: VW] = `IPVR_NMI_VEC;
    assign src_lvl[LW +: LW] = ubrk_req ? `IPVR_UB_LVL : `IPVR_NO_LVL;
    assign src_vec[VW +: VW] = `IPVR_UB_VEC;

    generate
        for (g = 0; g < `IPVR_NPINS; g = g + 1) begin : g_pin
            localparam [VW-1:0] PV = `IPVR_PIN_VEC + g;
            wire [`IPVR_FLD_W-1:0] f;
            assign f = fld_flat[g*`IPVR_FLD_W +: `IPVR_FLD_W];
            assign src_lvl[(2+g)*LW +: LW] =
                (external_request_pins[g] && (f != 4'h0)) ?
                {1'b0, f} : `IPVR_NO_LVL;
            // pins take consecutive vectors from 64
            assign src_vec[(2+g)*VW +: VW] = PV;
        end
    endgenerate

    generate
        for (g = 0; g < `IPVR_NPFLD*`IPVR_NSLOT; g = g + 1) begin : g_per
            localparam K = g / `IPVR_NSLOT;
            localparam S = g % `IPVR_NSLOT;
            localparam DMA = (K < `IPVR_DMA_FLDS);
            localparam STEP = DMA ? `IPVR_DMA_STEP : 1;
            // dma fields hold two slots only, so vectors never overlap
            localparam LIVE = !(DMA && (S * STEP >= `IPVR_FLD_SPAN));
            localparam [VW-1:0] VEC =
                `IPVR_PER_VEC + `IPVR_FLD_SPAN * K + S * STEP;
            wire [`IPVR_FLD_W-1:0] f;
            assign f = fld_flat[(`IPVR_NPINS+K)*`IPVR_FLD_W +: `IPVR_FLD_W];
            // level 0 masks the whole field
            assign src_lvl[(2+`IPVR_NPINS+g)*LW +: LW] =
                (LIVE && periph_req[g] && (f != 4'h0)) ?
                {1'b0, f} : `IPVR_NO_LVL;
            assign src_vec[(2+`IPVR_NPINS+g)*VW +: VW] = VEC;
        end
    endgenerate

    // ---------------- resolution chain ----------------
    // a linear chain is slow but gives the fixed order for free
    wire [LW*(NSRC+1)-1:0] ch_lvl;
    wire [VW*(NSRC+1)-1:0] ch_vec;
    assign ch_lvl[0 +: LW] = `IPVR_NO_LVL;
    assign ch_vec[0 +: VW] = {VW{1'b0}};

    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_chain
            // slot order inside a field is fixed by position
            ipvr_pick #(
                .LVL_W(LW),
                .VEC_W(VW)
            ) u_pick (
                .in_lvl(ch_lvl[g*LW +: LW]),
                .in_vec(ch_vec[g*VW +: VW]),
                .cand_lvl(src_lvl[g*LW +: LW]),
                .cand_vec(src_vec[g*VW +: VW]),
                .out_lvl(ch_lvl[(g+1)*LW +: LW]),
                .out_vec(ch_vec[(g+1)*VW +: VW])
            );
        end
    endgenerate

    wire [LW-1:0] win_lvl;
    wire [VW-1:0] win_vec;
    wire win_ok;
    assign win_lvl = ch_lvl[NSRC*LW +: LW];
    assign win_vec = ch_vec[NSRC*VW +: VW];
    // only above the cpu mask; nmi level 16 always passes
    assign win_ok = (win_lvl > {1'b0, cpu_mask_lvl});

    // ---------------- cpu outputs ----------------
    reg req_reg;
    reg [VW-1:0] vec_reg;
    reg [LW-1:0] lvl_reg;
    reg [`IPVR_FLD_W-1:0] nmask_reg;
    wire [`IPVR_FLD_W-1:0] nmask_next;
    wire accepted;
    wire [`IPVR_NEVT-1:0] evt;

    // nmi and break raise the mask to 15, others to their level
    assign nmask_next = (win_lvl[LW-1] || win_vec == `IPVR_UB_VEC) ?
        `IPVR_TOP_MASK : win_lvl[`IPVR_FLD_W-1:0];
    assign accepted = req_reg & cpu_ack;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_reg <= 1'b0;
            vec_reg <= {VW{1'b0}};
            lvl_reg <= `IPVR_NO_LVL;
            nmask_reg <= 4'h0;
        end else if (accepted) begin
            // drop for one cycle so the served source can withdraw
            req_reg <= 1'b0;
        end else begin
            req_reg <= win_ok;
            if (win_ok) begin
                vec_reg <= win_vec;
                lvl_reg <= win_lvl;
                nmask_reg <= nmask_next;
            end
        end
    end

    assign cpu_req = req_reg;
    assign cpu_vec = vec_reg;
    assign cpu_lvl = lvl_reg;
    assign cpu_new_mask = nmask_reg;
    // table offset is vector times four
    // cpu reads its routine address from this offset
    assign cpu_vec_addr = {{(32-VW-2){1'b0}}, vec_reg, 2'b00};

    // ---------------- events and interrupt ----------------
    wire [`IPVR_NEVT-1:0] stat_w;
    wire [`IPVR_NEVT-1:0] mask_w;
    assign evt[`IPVR_EVT_ACC] = accepted;
    assign evt[`IPVR_EVT_NMI] = accepted & (vec_reg == `IPVR_NMI_VEC);

    ipvr_evt #(
        .W(`IPVR_NEVT)
    ) u_evt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .evt(evt),
        .clr_we(apb_wr & hit_stat & pstrb[0]),
        .clr_data(pwdata[`IPVR_NEVT-1:0]),
        .mask_we(apb_wr & hit_mask & pstrb[0]),
        .mask_data(pwdata[`IPVR_NEVT-1:0]),
        .status(stat_w),
        .mask(mask_w),
        .irq(irq)
    );

    // ---------------- apb read path ----------------
    // data is sampled in setup so the access phase needs no wait
    reg [31:0] rdata_reg;
    reg err_reg;
    reg [31:0] rdata_next;

    always @* begin
        rdata_next = 32'h0000_0000;
        if (hit_prio) begin
            rdata_next = {16'h0000, prio_reg[prio_idx]};
        end else if (hit_stat) begin
            rdata_next = {{(32-`IPVR_NEVT){1'b0}}, stat_w};
        end else if (hit_mask) begin
            rdata_next = {{(32-`IPVR_NEVT){1'b0}}, mask_w};
        end else if (hit_cur) begin
            rdata_next = {11'h000, req_reg, nmask_reg, 3'h0, lvl_reg,
                vec_reg};
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (apb_setup) begin
            rdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
            // current-state word is read only
            err_reg <= ~hit_any | (pwrite & hit_cur);
        end
    end

    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = err_reg & psel & penable;
endmodule
`default_nettype wire

/* File: testbench/ipvr_props.sv */
// assertion checker on the resolver top-level ports
`timescale 1ns/1ps
`default_nettype none
module ipvr_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic nmi_req,
    input wire logic ubrk_req,
    input wire logic [7:0] external_request_pins,
    input wire logic [95:0] periph_req,
    input wire logic [3:0] cpu_mask_lvl,
    input wire logic cpu_ack,
    input wire logic cpu_req,
    input wire logic [7:0] cpu_vec,
    input wire logic [4:0] cpu_lvl,
    input wire logic [31:0] cpu_vec_addr,
    input wire logic [3:0] cpu_new_mask,
    input wire logic irq
);
default clocking dc @(posedge clk_sys);
endclocking
default disable iff (!rst_n);
addr_calc_a: assert property (
    cpu_vec_addr == {22'h0, cpu_vec, 2'h0}) else $error("bad table addr");
nmi_take_a: assert property (
    nmi_req && !(cpu_req && cpu_ack) |=> cpu_req && cpu_vec == 8'h0B &&
    cpu_lvl == 5'h10 && cpu_new_mask == 4'hF) else $error("nmi not taken");
brk_take_a: assert property (
    ubrk_req && !nmi_req && cpu_mask_lvl != 4'hF && !(cpu_req && cpu_ack)
    |=> cpu_req && cpu_vec == 8'h0C && cpu_lvl == 5'h0F)
    else $error("break not taken");
ack_gap_a: assert property (
    cpu_req && cpu_ack |=> !cpu_req) else $error("no gap after ack");
above_mask_a: assert property (
    cpu_req && cpu_lvl != 5'h10 |-> cpu_lvl > {1'b0, $past(cpu_mask_lvl)})
    else $error("level not above mask");
new_mask_a: assert property (
    cpu_req |-> cpu_new_mask == (cpu_lvl > 5'h0E ? 4'hF : cpu_lvl[3:0]))
    else $error("bad new mask");
idle_none_a: assert property (
    !nmi_req && !ubrk_req && external_request_pins == 8'h00 &&
    periph_req == 96'h0 |=> !cpu_req) else $error("request from nothing");
vec_hold_a: assert property (
    !cpu_req ##1 !cpu_req |-> $stable(cpu_vec) && $stable(cpu_lvl))
    else $error("vector moved while idle");
cover property (cpu_req && cpu_ack);
cover property (cpu_req && cpu_lvl == 5'h10);
cover property (irq);
endmodule
bind ipvr_top ipvr_props i_props (.*);
`default_nettype wire

/* File: testbench/ipvr_cpu_model.sv */
// cpu core stand-in: accepts requests and fetches the vector entry
`timescale 1ns/1ps
`default_nettype none
module ipvr_cpu_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cpu_req,
    input wire logic [31:0] cpu_vec_addr,
    input wire logic [3:0] slow,
    output var logic cpu_ack,
    output var logic [31:0] fetched
);
logic [3:0] wait_reg;
// table contents arbitrary, only the lookup matters
function automatic logic [31:0] vtab(input logic [31:0] a);
    vtab = 32'h0800_0000 | {a[29:0], 2'h0};
endfunction
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        cpu_ack <= 1'b0;
        wait_reg <= 4'h0;
        fetched <= 32'h0;
    end else if (cpu_ack) begin
        cpu_ack <= 1'b0;
        wait_reg <= 4'h0;
        // routine read from the supplied entry
        fetched <= vtab(cpu_vec_addr);
    end else if (cpu_req) begin
        wait_reg <= wait_reg + 4'h1;
        cpu_ack <= wait_reg >= slow;
    end
end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the priority resolver
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic [3:0] pstrb = 4'hF;
logic nmi_req = 1'b0;
logic ubrk_req = 1'b0;
logic [7:0] external_request_pins = 8'h00;
logic [95:0] periph_req = 96'h0;
logic [3:0] cpu_mask_lvl = 4'h0;
logic [3:0] slow = 4'h0;
wire logic pready, pslverr, cpu_ack, cpu_req, irq;
wire logic [31:0] prdata, cpu_vec_addr, fetched;
wire logic [7:0] cpu_vec;
wire logic [4:0] cpu_lvl;
wire logic [3:0] cpu_new_mask;
logic [31:0] rd;
logic er;
integer fails = 0;
integer n_tests = 0;
integer cyc = 0;
logic [31:0] fexp = 32'h0;
logic fchk = 1'b0;
always #2 clk_sys = ~clk_sys;
ipvr_top i_ipvr_top (.*);
ipvr_cpu_model i_ipvr_cpu_model (.*);
task complete_run;
    begin
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k = k + 1;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    end
endtask
task rdx(input logic [7:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    end
endtask
// waits for an accepted request and checks what was handed over
task serve(input logic [31:0] a, input logic [3:0] m);
    integer k;
    begin
        k = 0;
        do begin
            @(negedge clk_sys);
            k = k + 1;
        end while (!(cpu_req === 1'b1 && cpu_ack === 1'b1) && k < 40);
        chk(cpu_vec_addr, a);
        chk(32'(cpu_new_mask), 32'(m));
        @(posedge clk_sys);
    end
endtask
task t_reset;
    integer i;
    begin
        for (i = 0; i < 10; i = i + 1)
            rdx(8'(4 * i), 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, 8'h28, 32'h0);
        chk(32'(er), 32'h1);
        $display("reset test done");
    end
endtask
task t_regs;
    integer i;
    logic [31:0] d;
    begin
        for (i = 0; i < 8; i = i + 1) begin
            d = 32'hFFFF_FFFF - 32'h1111 * i;
            apb(1'b1, 8'(4 * i), d);
            rdx(8'(4 * i), d & 32'h0000_FFFF);
        end
        $display("register test done");
    end
endtask
task t_pins;
    integer n;
    logic [31:0] lv;
    begin
        lv = 32'h1234_5F9A;
        apb(1'b1, 8'h00, {16'h0, lv[31:16]});
        apb(1'b1, 8'h04, {16'h0, lv[15:0]});
        for (n = 0; n < 8; n = n + 1) begin
            slow <= 4'(n);
            external_request_pins <= 8'h01 << n;
            serve(32'(4 * (64 + n)), lv[31 - 4 * n -: 4]);
            external_request_pins <= 8'h00;
            repeat (2) @(posedge clk_sys);
        end
        $display("pin test done");
    end
endtask
task t_tie;
    begin
        apb(1'b1, 8'h00, 32'h5555);
        apb(1'b1, 8'h04, 32'h5555);
        apb(1'b1, 8'h08, 32'h5000);
        external_request_pins <= 8'h48;
        periph_req <= 96'h3;
        serve(32'd268, 4'h5);
        external_request_pins <= 8'h40;
        serve(32'd280, 4'h5);
        external_request_pins <= 8'h00;
        serve(32'd288, 4'h5);
        periph_req <= 96'h2;
        serve(32'd296, 4'h5);
        periph_req <= 96'h0;
        $display("tie test done");
    end
endtask
task t_mask;
    begin
        apb(1'b1, 8'h00, 32'h5000);
        cpu_mask_lvl <= 4'h5;
        external_request_pins <= 8'h03;
        repeat (6) @(negedge clk_sys);
        chk(32'(cpu_req), 32'h0);
        @(posedge clk_sys);
        cpu_mask_lvl <= 4'h4;
        serve(32'd256, 4'h5);
        external_request_pins <= 8'h02;
        repeat (6) @(negedge clk_sys);
        chk(32'(cpu_req), 32'h0);
        @(posedge clk_sys);
        rdx(8'h28, 32'h0005_0540);
        external_request_pins <= 8'h00;
        $display("mask test done");
    end
endtask
task t_nmi;
    begin
        apb(1'b1, 8'h24, 32'h2);
        cpu_mask_lvl <= 4'hF;
        nmi_req <= 1'b1;
        serve(32'd44, 4'hF);
        nmi_req <= 1'b0;
        @(posedge clk_sys);
        chk(32'(irq), 32'h1);
        apb(1'b1, 8'h20, 32'h2);
        chk(32'(irq), 32'h0);
        cpu_mask_lvl <= 4'hE;
        ubrk_req <= 1'b1;
        serve(32'd48, 4'hF);
        ubrk_req <= 1'b0;
        apb(1'b1, 8'h24, 32'h1);
        chk(32'(irq), 32'h1);
        apb(1'b1, 8'h24, 32'h0);
        chk(32'(irq), 32'h0);
        $display("nmi test done");
    end
endtask
initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_regs;
    t_pins;
    t_tie;
    t_mask;
    t_nmi;
    complete_run;
end
// entry fetched one edge after each acceptance
always @(posedge clk_sys) begin
    fchk <= (cpu_req === 1'b1 && cpu_ack === 1'b1);
    fexp <= 32'h0800_0000 | {cpu_vec_addr[29:0], 2'h0};
    if (fchk) begin
        chk(fetched, fexp);
    end
end
always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
        fails = fails + 1;
        complete_run;
    end
end
endmodule
`default_nettype wire
